/* rtl/quad_decoder_spi_clock_pin_mux.sv */
// pin multiplexer and pull-up control for port C pins 5..7 and port E pin 4
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

module quad_decoder_spi_clock_pin_mux
    import pin_mux_pkg::*;
(
    // clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       ce,
    // function select, two bits per pin: C5, C6, C7, E4 from bit 0 up
    input  wire logic       func_we,
    input  wire logic [7:0] func_wdata,
    output logic      [7:0] func_code,
    // general-purpose direction and output data, one bit per pin
    input  wire logic       gpio_dir_we,
    input  wire logic [3:0] gpio_dir_wdata,
    output logic      [3:0] gpio_dir,
    input  wire logic       gpio_out_we,
    input  wire logic [3:0] gpio_out_wdata,
    output logic      [3:0] gpio_out,
    output logic      [3:0] gpio_in,
    // pull-up enables
    input  wire logic       pu_c_we,
    input  wire logic [7:0] pu_c_wdata,
    output logic      [7:0] port_c_pullup_enable,
    input  wire logic       pu_e_we,
    input  wire logic [7:0] pu_e_wdata,
    output logic      [7:0] port_e_pullup_enable,
    // quadrature decoder 0 inputs
    output logic            quad0_phase_b_in,
    output logic            quad0_index_in,
    output logic            quad0_home_in,
    // timer A channels
    input  wire logic       timer_a_channel_1_out,
    input  wire logic       timer_a_channel_1_oe,
    output logic            timer_a_channel_1_in,
    input  wire logic       timer_a_channel_2_out,
    input  wire logic       timer_a_channel_2_oe,
    output logic            timer_a_channel_2_in,
    input  wire logic       timer_a_channel_3_out,
    input  wire logic       timer_a_channel_3_oe,
    output logic            timer_a_channel_3_in,
    // SPI 0 serial clock, core side
    input  wire logic       spi0_master,
    input  wire logic       spi0_serial_clock_pin_out,
    output logic            spi0_serial_clock_pin_in,
    // pads
    input  wire logic       port_c_pin_5_in,
    output logic            port_c_pin_5_out,
    output logic            port_c_pin_5_oe,
    input  wire logic       port_c_pin_6_in,
    output logic            port_c_pin_6_out,
    output logic            port_c_pin_6_oe,
    input  wire logic       port_c_pin_7_in,
    output logic            port_c_pin_7_out,
    output logic            port_c_pin_7_oe,
    input  wire logic       port_e_pin_4_in,
    output logic            port_e_pin_4_out,
    output logic            port_e_pin_4_oe
);

    localparam int NPIN = 4;

    pin_func_t  func_q [NPIN];
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] periph_out;
    logic [3:0] periph_oe;
    logic [3:0] timer_out;
    logic [3:0] timer_oe;

    ////////////////////////////////////////////////////////////////////////////
    // pad gathering

    assign pin_in = {port_e_pin_4_in, port_c_pin_7_in, port_c_pin_6_in, port_c_pin_5_in};

    assign port_c_pin_5_out = pin_out[0];
    assign port_c_pin_5_oe  = pin_oe[0];
    assign port_c_pin_6_out = pin_out[1];
    assign port_c_pin_6_oe  = pin_oe[1];
    assign port_c_pin_7_out = pin_out[2];
    assign port_c_pin_7_oe  = pin_oe[2];
    assign port_e_pin_4_out = pin_out[3];
    assign port_e_pin_4_oe  = pin_oe[3];

    // decoder inputs never drive; only the serial clock pin drives, and only as master
    assign periph_out = {spi0_serial_clock_pin_out, 3'h0};
    assign periph_oe  = {spi0_master, 3'h0};
    assign timer_out  = {1'b0, timer_a_channel_3_out, timer_a_channel_2_out,
                         timer_a_channel_1_out};
    assign timer_oe   = {1'b0, timer_a_channel_3_oe, timer_a_channel_2_oe,
                         timer_a_channel_1_oe};

    ////////////////////////////////////////////////////////////////////////////
    // function select

    // an illegal code leaves that pin's selection as it was
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NPIN; i++)
            begin
                func_q[i] <= FUNC_PERIPH;
            end
            func_code <= `FUNC_CODE_RST;
        end
        else if (ce && func_we)
        begin
            for (int i = 0; i < NPIN; i++)
            begin
                if (func_legal(func_wdata[2*i +: 2], i != `SCLK_PIN_IDX))
                begin
                    func_q[i]             <= func_decode(func_wdata[2*i +: 2]);
                    func_code[2*i +: 2]   <= func_wdata[2*i +: 2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    cfg_reg #(.W(4), .RST(`GPIO_DIR_RST), .MASK(4'hf)) u_gpio_dir (
        .mclk  (mclk),
        .rstn  (rstn),
        .ce    (ce),
        .we    (gpio_dir_we),
        .wdata (gpio_dir_wdata),
        .q     (gpio_dir)
    );

    cfg_reg #(.W(4), .RST(`GPIO_OUT_RST), .MASK(4'hf)) u_gpio_out (
        .mclk  (mclk),
        .rstn  (rstn),
        .ce    (ce),
        .we    (gpio_out_we),
        .wdata (gpio_out_wdata),
        .q     (gpio_out)
    );

    cfg_reg #(.W(8), .RST(`PORT_C_PU_RST), .MASK(`PORT_C_PU_MASK)) u_pu_c (
        .mclk  (mclk),
        .rstn  (rstn),
        .ce    (ce),
        .we    (pu_c_we),
        .wdata (pu_c_wdata),
        .q     (port_c_pullup_enable)
    );

    cfg_reg #(.W(8), .RST(`PORT_E_PU_RST), .MASK(`PORT_E_PU_MASK)) u_pu_e (
        .mclk  (mclk),
        .rstn  (rstn),
        .ce    (ce),
        .we    (pu_e_we),
        .wdata (pu_e_wdata),
        .q     (port_e_pullup_enable)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pad drivers

    for (genvar g = 0; g < NPIN; g++)
    begin : g_pad
        pad_mux u_pad (
            .mclk       (mclk),
            .rstn       (rstn),
            .ce         (ce),
            .func       (func_q[g]),
            .periph_out (periph_out[g]),
            .periph_oe  (periph_oe[g]),
            .timer_out  (timer_out[g]),
            .timer_oe   (timer_oe[g]),
            .gpio_out   (gpio_out[g]),
            .gpio_dir   (gpio_dir[g]),
            .pad_out    (pin_out[g]),
            .pad_oe     (pin_oe[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // inbound routing

    // unselected consumers see a steady low instead of a toggling pad
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            quad0_phase_b_in <= 1'b0;
            quad0_index_in   <= 1'b0;
            quad0_home_in    <= 1'b0;
        end
        else if (ce)
        begin
            quad0_phase_b_in <= (func_q[0] == FUNC_PERIPH) && pin_in[0];
            quad0_index_in   <= (func_q[1] == FUNC_PERIPH) && pin_in[1];
            quad0_home_in    <= (func_q[2] == FUNC_PERIPH) && pin_in[2];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            timer_a_channel_1_in <= 1'b0;
            timer_a_channel_2_in <= 1'b0;
            timer_a_channel_3_in <= 1'b0;
        end
        else if (ce)
        begin
            timer_a_channel_1_in <= (func_q[0] == FUNC_TIMER) && pin_in[0];
            timer_a_channel_2_in <= (func_q[1] == FUNC_TIMER) && pin_in[1];
            timer_a_channel_3_in <= (func_q[2] == FUNC_TIMER) && pin_in[2];
        end
    end

    // as master the core makes the clock itself, so it gets no echo of the pad
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            spi0_serial_clock_pin_in <= 1'b0;
        end
        else if (ce)
        begin
            spi0_serial_clock_pin_in <= (func_q[`SCLK_PIN_IDX] == FUNC_PERIPH)
                                        && !spi0_master && pin_in[`SCLK_PIN_IDX];
        end
    end

    // pads read back whatever the selected function is
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            gpio_in <= 4'h0;
        end
        else if (ce)
        begin
            gpio_in <= pin_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence sclk_slave_s;
        ce && func_q[`SCLK_PIN_IDX] == FUNC_PERIPH && !spi0_master;
    endsequence

    sequence sclk_master_s;
        ce && func_q[`SCLK_PIN_IDX] == FUNC_PERIPH && spi0_master;
    endsequence

    c5_reset_route_a: assert property (disable iff (1'b0)
        !rstn |=> func_q[0] == FUNC_PERIPH)
        else $error("port c pin 5 not on phase b after reset");
    c6_reset_route_a: assert property (disable iff (1'b0)
        !rstn |=> func_q[1] == FUNC_PERIPH)
        else $error("port c pin 6 not on index after reset");
    c7_reset_route_a: assert property (disable iff (1'b0)
        !rstn |=> func_q[2] == FUNC_PERIPH)
        else $error("port c pin 7 not on home after reset");
    e4_reset_route_a: assert property (disable iff (1'b0)
        !rstn |=> func_q[3] == FUNC_PERIPH && !port_e_pin_4_oe)
        else $error("port e pin 4 not on serial clock after reset");

    phase_b_path_a: assert property (ce && func_q[0] == FUNC_PERIPH
        |=> quad0_phase_b_in == $past(pin_in[0]))
        else $error("phase b input does not follow pin");

    pu_c_clear_a: assert property (ce && pu_c_we
        |=> port_c_pullup_enable == ($past(pu_c_wdata) & `PORT_C_PU_MASK))
        else $error("port c pull-up write not applied");

    pu_e_clear_a: assert property (ce && pu_e_we && !pu_e_wdata[`PORT_E_PIN_4_BIT]
        |=> !port_e_pullup_enable[`PORT_E_PIN_4_BIT])
        else $error("port e pull-up not cleared");

    sclk_master_drive_a: assert property (sclk_master_s
        |=> port_e_pin_4_oe && port_e_pin_4_out == $past(spi0_serial_clock_pin_out))
        else $error("serial clock not driven as master");

    sclk_slave_in_a: assert property (sclk_slave_s
        |=> !port_e_pin_4_oe && spi0_serial_clock_pin_in == $past(port_e_pin_4_in))
        else $error("serial clock not taken as slave input");

    timer_ch2_drive_a: assert property (ce && func_q[1] == FUNC_TIMER
        |=> port_c_pin_6_oe == $past(timer_a_channel_2_oe)
            && port_c_pin_6_out == $past(timer_a_channel_2_out))
        else $error("timer channel 2 not on pin");

    gpio_dir_c7_a: assert property (ce && func_q[2] == FUNC_GPIO
        |=> port_c_pin_7_oe == $past(gpio_dir[2]))
        else $error("gpio direction not applied on pin");

    func_onehot_a: assert property ($onehot(func_q[0]) && $onehot(func_q[1])
        && $onehot(func_q[2]) && func_q[3] != FUNC_TIMER)
        else $error("pin function select not a single source");

    freeze_a: assert property (!ce |=> $stable(func_code) && $stable(pin_oe)
        && $stable(port_c_pullup_enable))
        else $error("state changed while clock enable low");

endmodule

/* rtl/pin_mux_regs.svh */
// constant values for the shared-pin multiplexer: codes, bit positions, reset values
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// function select codes, two bits per pin
`define FUNC_CODE_W        2
`define FUNC_CODE_PERIPH   2'h0
`define FUNC_CODE_TIMER    2'h1
`define FUNC_CODE_GPIO     2'h2
`define FUNC_CODE_RST      8'h00

// pin positions inside the two port pull-up registers
`define PORT_C_PIN_5_BIT   5
`define PORT_C_PIN_6_BIT   6
`define PORT_C_PIN_7_BIT   7
`define PORT_E_PIN_4_BIT   4

// pull-up registers: implemented bits and reset values (pull-ups on)
`define PORT_C_PU_MASK     8'he0
`define PORT_C_PU_RST      8'he0
`define PORT_E_PU_MASK     8'h10
`define PORT_E_PU_RST      8'h10

// general-purpose reset values: all inputs, output data low
`define GPIO_DIR_RST       4'h0
`define GPIO_OUT_RST       4'h0

// index of the serial clock pin in the per-pin arrays
`define SCLK_PIN_IDX       3

`endif

/* rtl/pin_mux_pkg.sv */
// types and helpers shared by the shared-pin multiplexer modules
package pin_mux_pkg;
`include "pin_mux_regs.svh"

    typedef enum logic [2:0] {
        FUNC_PERIPH = 3'b001,
        FUNC_TIMER  = 3'b010,
        FUNC_GPIO   = 3'b100
    } pin_func_t;

    // a timer code on a pin without a timer channel, or code 3, is not legal
    function automatic logic func_legal(input logic [1:0] code, input logic has_timer);
        func_legal = (code == `FUNC_CODE_PERIPH) || (code == `FUNC_CODE_GPIO)
                     || ((code == `FUNC_CODE_TIMER) && has_timer);
    endfunction

    function automatic pin_func_t func_decode(input logic [1:0] code);
        unique case (code)
            `FUNC_CODE_TIMER: func_decode = FUNC_TIMER;
            `FUNC_CODE_GPIO:  func_decode = FUNC_GPIO;
            default:          func_decode = FUNC_PERIPH;
        endcase
    endfunction

endpackage

/* rtl/cfg_reg.sv */
// loadable configuration register with synchronous reset value and clock enable
`timescale 1ns/1ps
module cfg_reg #(
    parameter int        W    = 8,
    parameter logic [W-1:0] RST  = '0,
    parameter logic [W-1:0] MASK = '1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // write side
    input  wire logic         we,
    input  wire logic [W-1:0] wdata,
    // stored value
    output logic      [W-1:0] q
);

    // unimplemented bits stay at zero whatever is written
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            q <= RST & MASK;
        end
        else if (ce && we)
        begin
            q <= wdata & MASK;
        end
    end

endmodule

/* rtl/pad_mux.sv */
// one pad's output driver selected from peripheral, timer or general-purpose source
`timescale 1ns/1ps
module pad_mux
    import pin_mux_pkg::*;
(
    // clock and reset
    input  wire logic      mclk,
    input  wire logic      rstn,
    input  wire logic      ce,
    // selection
    input  pin_func_t      func,
    // sources
    input  wire logic      periph_out,
    input  wire logic      periph_oe,
    input  wire logic      timer_out,
    input  wire logic      timer_oe,
    input  wire logic      gpio_out,
    input  wire logic      gpio_dir,
    // pad drive
    output logic           pad_out,
    output logic           pad_oe
);

    logic out_d;
    logic oe_d;

    // only the selected source reaches the pad, so no two drivers can fight
    always_comb
    begin
        unique case (func)
            FUNC_PERIPH:
            begin
                out_d = periph_out;
                oe_d  = periph_oe;
            end
            FUNC_TIMER:
            begin
                out_d = timer_out;
                oe_d  = timer_oe;
            end
            FUNC_GPIO:
            begin
                out_d = gpio_out;
                oe_d  = gpio_dir;
            end
            default:
            begin
                out_d = 1'b0;
                oe_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end
        else if (ce)
        begin
            pad_out <= out_d;
            pad_oe  <= oe_d;
        end
    end

endmodule

/* verification/pin_peer.sv */
// far-side peers on the four shared pins: encoder, timer partners, SPI master
`timescale 1ns/1ps
module pin_peer (
    // clock
    input  wire logic       mclk,
    // device pad drive, C5, C6, C7, E4 from bit 0 up
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe,
    // internal pull-ups
    input  wire logic [3:0] pu_on,
    // peer drive commanded by the bench
    input  wire logic [3:0] peer_en,
    input  wire logic [3:0] peer_val,
    // resolved pad level
    output logic      [3:0] pad
);
    logic [3:0] float_q = 4'h5;

    // a floating pin without pull-up wanders, so a stale level never passes for data
    always_ff @(posedge mclk)
    begin
        float_q <= ~pad;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (dev_oe[i])
                pad[i] = dev_out[i];
            else if (peer_en[i])
                pad[i] = peer_val[i];
            else if (pu_on[i])
                pad[i] = 1'b1;
            else
                pad[i] = float_q[i];
        end
    end
endmodule

/* verification/quad_decoder_spi_clock_pin_mux_tb_top.sv */
// self-checking bench for the shared-pin multiplexer
`timescale 1ns/1ps
`define CHK(name, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
        end \
    end
module quad_decoder_spi_clock_pin_mux_tb_top;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic       ce = 1'b1;
    logic       func_we = 1'b0;
    logic       gpio_dir_we = 1'b0;
    logic       gpio_out_we = 1'b0;
    logic       pu_c_we = 1'b0;
    logic       pu_e_we = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] func_code;
    logic [3:0] gpio_dir;
    logic [3:0] gpio_out;
    logic [3:0] gpio_in;
    logic [7:0] pu_c;
    logic [7:0] pu_e;
    logic       q_b;
    logic       q_idx;
    logic       q_home;
    logic [3:0] t_out = 4'h0;
    logic [3:0] t_oe = 4'h0;
    logic [2:0] t_in;
    logic       spi_master = 1'b0;
    logic       sclk_out = 1'b0;
    logic       sclk_in;
    logic [3:0] pad;
    logic [3:0] pad_out;
    logic [3:0] pad_oe;
    logic [3:0] peer_en = 4'h0;
    logic [3:0] peer_val = 4'h0;
    int         fail_count = 0;
    int         checked = 0;

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    quad_decoder_spi_clock_pin_mux u_quad_decoder_spi_clock_pin_mux (
        .mclk(mclk), .rstn(rstn), .ce(ce),
        .func_we(func_we), .func_wdata(wdata), .func_code(func_code),
        .gpio_dir_we(gpio_dir_we), .gpio_dir_wdata(wdata[3:0]), .gpio_dir(gpio_dir),
        .gpio_out_we(gpio_out_we), .gpio_out_wdata(wdata[3:0]), .gpio_out(gpio_out),
        .gpio_in(gpio_in),
        .pu_c_we(pu_c_we), .pu_c_wdata(wdata), .port_c_pullup_enable(pu_c),
        .pu_e_we(pu_e_we), .pu_e_wdata(wdata), .port_e_pullup_enable(pu_e),
        .quad0_phase_b_in(q_b), .quad0_index_in(q_idx), .quad0_home_in(q_home),
        .timer_a_channel_1_out(t_out[0]), .timer_a_channel_1_oe(t_oe[0]),
        .timer_a_channel_1_in(t_in[0]),
        .timer_a_channel_2_out(t_out[1]), .timer_a_channel_2_oe(t_oe[1]),
        .timer_a_channel_2_in(t_in[1]),
        .timer_a_channel_3_out(t_out[2]), .timer_a_channel_3_oe(t_oe[2]),
        .timer_a_channel_3_in(t_in[2]),
        .spi0_master(spi_master), .spi0_serial_clock_pin_out(sclk_out),
        .spi0_serial_clock_pin_in(sclk_in),
        .port_c_pin_5_in(pad[0]), .port_c_pin_5_out(pad_out[0]), .port_c_pin_5_oe(pad_oe[0]),
        .port_c_pin_6_in(pad[1]), .port_c_pin_6_out(pad_out[1]), .port_c_pin_6_oe(pad_oe[1]),
        .port_c_pin_7_in(pad[2]), .port_c_pin_7_out(pad_out[2]), .port_c_pin_7_oe(pad_oe[2]),
        .port_e_pin_4_in(pad[3]), .port_e_pin_4_out(pad_out[3]), .port_e_pin_4_oe(pad_oe[3])
    );

    pin_peer u_pin_peer (
        .mclk(mclk), .dev_out(pad_out), .dev_oe(pad_oe),
        .pu_on({pu_e[4], pu_c[7:5]}), .peer_en(peer_en), .peer_val(peer_val), .pad(pad)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // sel: 0 function, 1 direction, 2 output data, 3 port C pull-up, 4 port E pull-up
    task automatic wr(input int sel, input logic [7:0] v);
        @(negedge mclk);
        wdata = v;
        func_we = (sel == 0);
        gpio_dir_we = (sel == 1);
        gpio_out_we = (sel == 2);
        pu_c_we = (sel == 3);
        pu_e_we = (sel == 4);
        @(negedge mclk);
        {func_we, gpio_dir_we, gpio_out_we, pu_c_we, pu_e_we} = 5'h00;
    endtask

    task automatic t_reset;
        `CHK("func_code", 8'h00, func_code);
        `CHK("pullup_c", 8'he0, pu_c);
        `CHK("pullup_e", 8'h10, pu_e);
        `CHK("pad_oe", 4'h0, pad_oe);
        peer_en = 4'h7;
        peer_val = 4'h5;
        tick(1);
        `CHK("phase_b", 1'b1, q_b);
        `CHK("index", 1'b0, q_idx);
        `CHK("home", 1'b1, q_home);
        `CHK("timer_in", 3'h0, t_in);
        peer_val = 4'h2;
        tick(1);
        `CHK("quad_inputs", 3'h2, {q_home, q_idx, q_b});
        peer_en = 4'h0;
        $display("test reset done");
    endtask

    task automatic t_pullup;
        wr(3, 8'hff);
        `CHK("pullup_c", 8'he0, pu_c);
        wr(3, 8'h20);
        `CHK("pullup_c", 8'h20, pu_c);
        wr(4, 8'hff);
        `CHK("pullup_e", 8'h10, pu_e);
        wr(4, 8'hef);
        `CHK("pullup_e", 8'h00, pu_e);
        ce = 1'b0;
        wr(3, 8'he0);
        `CHK("pullup_c_frozen", 8'h20, pu_c);
        ce = 1'b1;
        wr(3, 8'he0);
        wr(4, 8'h10);
        tick(1);
        `CHK("phase_b_pulled", 1'b1, q_b);
        $display("test pullup done");
    endtask

    task automatic t_spi;
        spi_master = 1'b1;
        sclk_out = 1'b1;
        tick(1);
        `CHK("sclk_oe", 1'b1, pad_oe[3]);
        `CHK("sclk_out", 1'b1, pad_out[3]);
        sclk_out = 1'b0;
        tick(1);
        `CHK("sclk_out", 1'b0, pad_out[3]);
        `CHK("sclk_in_master", 1'b0, sclk_in);
        spi_master = 1'b0;
        tick(1);
        `CHK("sclk_oe_slave", 1'b0, pad_oe[3]);
        peer_en = 4'h8;
        peer_val = 4'h8;
        tick(1);
        `CHK("sclk_in", 1'b1, sclk_in);
        peer_val = 4'h0;
        tick(1);
        `CHK("sclk_in", 1'b0, sclk_in);
        peer_en = 4'h0;
        $display("test spi done");
    endtask

    task automatic t_timer;
        wr(0, 8'h15);
        `CHK("func_code", 8'h15, func_code);
        t_oe = 4'h3;
        t_out = 4'h1;
        tick(1);
        `CHK("pad_oe", 4'h3, pad_oe);
        `CHK("pad_out_c5_c6", 2'h1, pad_out[1:0]);
        peer_en = 4'h4;
        peer_val = 4'h0;
        tick(1);
        `CHK("timer_in", 3'h1, t_in[2:0]);
        peer_val = 4'h4;
        tick(1);
        `CHK("timer_in", 3'h5, t_in[2:0]);
        `CHK("home_unselected", 1'b0, q_home);
        t_oe = 4'h0;
        peer_en = 4'h0;
        $display("test timer done");
    endtask

    task automatic t_gpio;
        wr(0, 8'haa);
        wr(1, 8'h05);
        wr(2, 8'h0f);
        peer_en = 4'h2;
        peer_val = 4'h0;
        tick(1);
        `CHK("pad_oe", 4'h5, pad_oe);
        `CHK("pad_out", 4'h5, pad_out & pad_oe);
        `CHK("gpio_dir", 4'h5, gpio_dir);
        `CHK("gpio_out", 4'hf, gpio_out);
        tick(1);
        `CHK("gpio_in", 4'hd, gpio_in);
        `CHK("quad_unselected", 3'h0, {q_home, q_idx, q_b});
        peer_en = 4'h0;
        wr(1, 8'h0a);
        tick(1);
        `CHK("pad_oe", 4'ha, pad_oe);
        $display("test gpio done");
    endtask

    task automatic t_illegal;
        wr(0, 8'h5b);
        `CHK("func_code", 8'h9a, func_code);
        wr(1, 8'h00);
        wr(0, 8'h00);
        `CHK("func_code", 8'h00, func_code);
        $display("test illegal done");
    endtask

    // a cleared pull-up leaves the pin floating; a second reset restores every default
    task automatic t_rerun;
        logic v;
        wr(0, 8'haa);
        wr(1, 8'h0e);
        wr(3, 8'h00);
        `CHK("pullup_c", 8'h00, pu_c);
        tick(1);
        v = gpio_in[0];
        tick(1);
        `CHK("c5_pull_off", ~v, gpio_in[0]);
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(1);
        `CHK("func_code", 8'h00, func_code);
        `CHK("gpio_dir", 4'h0, gpio_dir);
        `CHK("gpio_out", 4'h0, gpio_out);
        `CHK("pullup_c", 8'he0, pu_c);
        `CHK("pad_oe", 4'h0, pad_oe);
        $display("test rerun done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(16);
        rstn = 1'b1;
        tick(1);
        t_reset();
        t_pullup();
        t_spi();
        t_timer();
        t_gpio();
        t_illegal();
        t_rerun();
        finish_test();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        #50000;
        fail_count++;
        finish_test();
    end
endmodule
